// file: cpsm_pkg.sv
// package: constants and types for the configuration port state machine
package cpsm_pkg;

  localparam int unsigned CLK_FREQ_HZ = 40_000_000;
  localparam int unsigned QUIET_US    = 500;
  localparam int unsigned QUIET_CYCLES =
    (QUIET_US * (CLK_FREQ_HZ / 1_000_000));

  localparam logic [15:0] BASE_STRAP_LO = 16'h002E;
  localparam logic [15:0] BASE_STRAP_HI = 16'h004E;
  localparam logic [15:0] DATA_PORT_OFS = 16'h0001;

  localparam logic [7:0] KEY_ENTER = 8'h55;
  localparam logic [7:0] KEY_EXIT  = 8'hAA;

  localparam logic [7:0] IDX_CONFIG_CONTROL   = 8'h02;
  localparam logic [7:0] IDX_RESERVED_ZERO_A  = 8'h03;
  localparam logic [7:0] IDX_UNIT_SELECT      = 8'h07;
  localparam logic [7:0] IDX_PART_IDENTIFIER  = 8'h20;
  localparam logic [7:0] IDX_PART_REVISION    = 8'h21;
  localparam logic [7:0] IDX_UNIT_POWER       = 8'h22;
  localparam logic [7:0] IDX_POWER_MANAGEMENT = 8'h23;
  localparam logic [7:0] IDX_OSCILLATOR       = 8'h24;
  localparam logic [7:0] IDX_PORT_BASE_LOW    = 8'h26;
  localparam logic [7:0] IDX_PORT_BASE_HIGH   = 8'h27;
  localparam logic [7:0] IDX_RESERVED_B       = 8'h28;
  localparam logic [7:0] IDX_TEST_SIX         = 8'h2A;
  localparam logic [7:0] IDX_TEST_FOUR        = 8'h2B;
  localparam logic [7:0] IDX_TEST_FIVE        = 8'h2C;
  localparam logic [7:0] IDX_GLOBAL_LAST      = 8'h2F;
  localparam logic [7:0] IDX_ACTIVATE         = 8'h30;

  localparam int unsigned SOFT_RESET_BIT = 0;
  localparam int unsigned UNIT_COUNT     = 8;

  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_OSCILLATOR = 8'h04;

  // arbitrary identity values
  localparam logic [7:0] PART_ID_VALUE  = 8'hA5;
  localparam logic [7:0] PART_REV_VALUE = 8'h01;

  typedef enum logic [0:0] {
    CPSM_RUN    = 1'b0,
    CPSM_CONFIG = 1'b1
  } cpsm_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpsm_req_t;

endpackage

// file: cpsm_config_port.sv
// module: configuration port decoder, index/data access, global registers
`timescale 1ns/1ps
// Overview of operation
// [RQ1] bus or power reset leaves run state, all logical units disabled
// [RQ2] strap sampled at reset; low gives base 0x02E, high 0x04E
// [RQ3] base relocatable via index 0x26/0x27, reloaded from strap at reset
// [RQ4] writing 0x55 to config port enters configuration state
// [RQ5] writing 0xAA to config port returns to run state
// [RQ6] index and data ports respond only in configuration state
// [RQ7] index at base address, data at base plus one, index readable
// [RQ8] index 0x07 selects logical unit; later accesses go to that unit
// [RQ9] global registers reachable regardless of selected unit
// [RQ10] exactly two states; entry key accepted in run state outside reset and the quiet window
// [RQ11] bit 0 of control register does soft reset of soft defaults
// [RQ12] all host accesses ignored for 500 us after power reset
// [RQ13] reading global index 0x03 returns zero
// [RQ14] index 0x20 and 0x21 return fixed id and revision, read only
// [RQ15] strap sampled only at reset, otherwise pin is general purpose
// [RQ16] other bytes written in run state are ignored
// [RQ17] non-exit writes to index address in config state set index
module cpsm_config_port
  import cpsm_pkg::*;
(
  input  wire logic                  clock_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  bus_reset_n_in,
  input  wire logic                  power_reset_n_in,
  input  wire logic                  strap_in,
  input  wire cpsm_req_t             req_in,
  output logic [7:0]                 rdata_out,
  output logic                       rvalid_out,
  output logic                       config_mode_out,
  output logic [7:0]                 unit_select_out,
  output logic [UNIT_COUNT-1:0]      unit_active_out,
  output logic                       shared_gpio_line_out,
  output logic [7:0]                 unit_power_out,
  output logic [7:0]                 power_management_out
);

  cpsm_state_t          state_reg;
  logic [7:0]           index_reg;
  logic [7:0]           unit_sel_reg;
  logic [UNIT_COUNT-1:0] active_reg;
  logic [7:0]           power_ctl_reg;
  logic [7:0]           power_mgmt_reg;
  logic [7:0]           osc_reg;
  logic [7:0]           base_low_reg;
  logic [7:0]           base_high_reg;
  logic [7:0]           test6_reg;
  logic [7:0]           test4_reg;
  logic [7:0]           test5_reg;
  logic [7:0]           rdata_reg;
  logic                 rvalid_reg;
  logic                 bus_rst_d_reg;
  logic                 gpio_reg;
  logic [14:0]          quiet_reg;
  logic                 pwr_d_reg;

  logic        bus_fall;
  logic        pwr_rise;
  logic        hard_reset;
  logic        quiet;
  logic [15:0] base_addr;
  logic        hit_index;
  logic        hit_data;
  logic        wr_index;
  logic        wr_data;
  logic        rd_data;
  logic        soft_reset;
  logic [7:0]  data_rd_value;
  logic [7:0]  strap_low_byte;

  // reset events: bus reset falling edge, power reset release
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_rst_d_reg <= 1'b1;
      pwr_d_reg     <= 1'b0;
    end else begin
      bus_rst_d_reg <= bus_reset_n_in;
      pwr_d_reg     <= power_reset_n_in;
    end
  end

  assign bus_fall   = bus_rst_d_reg && !bus_reset_n_in;
  assign pwr_rise   = !pwr_d_reg && power_reset_n_in;
  assign hard_reset = bus_fall || !bus_reset_n_in || !power_reset_n_in;

  // quiet window after power reset
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      quiet_reg <= 15'(QUIET_CYCLES);
    end else if (!power_reset_n_in) begin
      quiet_reg <= 15'(QUIET_CYCLES); // RQ12
    end else if (quiet_reg != 15'h0000) begin
      quiet_reg <= quiet_reg - 15'h0001; // RQ12
    end
  end

  assign quiet = (quiet_reg != 15'h0000); // RQ12

  assign base_addr = {base_high_reg, base_low_reg};
  assign strap_low_byte = strap_in ? BASE_STRAP_HI[7:0] : BASE_STRAP_LO[7:0];

  // decode; accesses dropped during reset and quiet window
  assign hit_index = (req_in.addr == base_addr); // RQ7
  assign hit_data  = (req_in.addr == base_addr + DATA_PORT_OFS); // RQ7
  assign wr_index  = req_in.wr && hit_index && !quiet && !hard_reset;
  assign wr_data   = req_in.wr && hit_data && !quiet && !hard_reset &&
                     (state_reg == CPSM_CONFIG); // RQ6
  assign rd_data   = req_in.rd && hit_data && !quiet && !hard_reset &&
                     (state_reg == CPSM_CONFIG); // RQ6
  assign soft_reset = wr_data && (index_reg == IDX_CONFIG_CONTROL) &&
                      req_in.wdata[SOFT_RESET_BIT]; // RQ11

  // two-state controller
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= CPSM_RUN;
    end else if (hard_reset) begin
      state_reg <= CPSM_RUN; // RQ1
    end else if (wr_index) begin
      case (state_reg)
        CPSM_RUN: begin
          if (req_in.wdata == KEY_ENTER) begin // RQ16
            state_reg <= CPSM_CONFIG; // RQ4 RQ10
          end
        end
        CPSM_CONFIG: begin
          if (req_in.wdata == KEY_EXIT) begin
            state_reg <= CPSM_RUN; // RQ5
          end
        end
        default: state_reg <= CPSM_RUN;
      endcase
    end
  end

  // index register
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      index_reg <= RST_ZERO;
    end else if (hard_reset) begin
      index_reg <= RST_ZERO;
    end else if (wr_index && state_reg == CPSM_CONFIG &&
                 req_in.wdata != KEY_EXIT) begin
      index_reg <= req_in.wdata; // RQ17
    end
  end

  // strap-loaded base address
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      base_low_reg  <= BASE_STRAP_LO[7:0];
      base_high_reg <= RST_ZERO;
    end else if (bus_fall || !power_reset_n_in) begin
      base_low_reg  <= strap_low_byte; // RQ2 RQ3 RQ15
      base_high_reg <= RST_ZERO; // RQ3
    end else if (wr_data && index_reg == IDX_PORT_BASE_LOW) begin
      base_low_reg <= req_in.wdata; // RQ3
    end else if (wr_data && index_reg == IDX_PORT_BASE_HIGH) begin
      base_high_reg <= req_in.wdata; // RQ3
    end
  end

  // pin acts as gpio outside reset
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gpio_reg <= 1'b0;
    end else if (!hard_reset) begin
      gpio_reg <= strap_in; // RQ15
    end
  end

  // unit select and per-unit activate
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      unit_sel_reg <= RST_ZERO;
      active_reg   <= '0;
    end else if (hard_reset) begin
      unit_sel_reg <= RST_ZERO;
      active_reg   <= '0; // RQ1
    end else if (soft_reset) begin
      unit_sel_reg <= RST_ZERO; // RQ11
      active_reg   <= '0; // RQ11
    end else if (wr_data && index_reg == IDX_UNIT_SELECT) begin
      unit_sel_reg <= req_in.wdata; // RQ8
    end else if (wr_data && index_reg == IDX_ACTIVATE &&
                 unit_sel_reg < 8'(UNIT_COUNT)) begin
      active_reg[unit_sel_reg[2:0]] <= req_in.wdata[0]; // RQ8
    end
  end

  // global read/write registers
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      power_ctl_reg  <= RST_ZERO;
      power_mgmt_reg <= RST_ZERO;
      osc_reg        <= RST_OSCILLATOR;
      test6_reg      <= RST_ZERO;
      test4_reg      <= RST_ZERO;
      test5_reg      <= RST_ZERO;
    end else if (hard_reset) begin
      power_ctl_reg  <= RST_ZERO;
      power_mgmt_reg <= RST_ZERO;
      osc_reg        <= RST_OSCILLATOR;
      if (!power_reset_n_in) begin
        test6_reg <= RST_ZERO;
        test4_reg <= RST_ZERO;
        test5_reg <= RST_ZERO;
      end
    end else if (soft_reset) begin
      power_ctl_reg <= RST_ZERO; // RQ11
    end else if (wr_data) begin
      case (index_reg) // RQ9
        IDX_UNIT_POWER:       power_ctl_reg  <= req_in.wdata;
        IDX_POWER_MANAGEMENT: power_mgmt_reg <= req_in.wdata;
        IDX_OSCILLATOR:       osc_reg        <= req_in.wdata;
        IDX_TEST_SIX:         test6_reg      <= req_in.wdata;
        IDX_TEST_FOUR:        test4_reg      <= req_in.wdata;
        IDX_TEST_FIVE:        test5_reg      <= req_in.wdata;
        default: begin
        end
      endcase
    end
  end

  // data port read mux
  always_comb begin
    case (index_reg) // RQ9
      IDX_RESERVED_ZERO_A:  data_rd_value = RST_ZERO; // RQ13
      IDX_UNIT_SELECT:      data_rd_value = unit_sel_reg;
      IDX_PART_IDENTIFIER:  data_rd_value = PART_ID_VALUE; // RQ14
      IDX_PART_REVISION:    data_rd_value = PART_REV_VALUE; // RQ14
      IDX_UNIT_POWER:       data_rd_value = power_ctl_reg;
      IDX_POWER_MANAGEMENT: data_rd_value = power_mgmt_reg;
      IDX_OSCILLATOR:       data_rd_value = osc_reg;
      IDX_PORT_BASE_LOW:    data_rd_value = base_low_reg;
      IDX_PORT_BASE_HIGH:   data_rd_value = base_high_reg;
      IDX_TEST_SIX:         data_rd_value = test6_reg;
      IDX_TEST_FOUR:        data_rd_value = test4_reg;
      IDX_TEST_FIVE:        data_rd_value = test5_reg;
      IDX_ACTIVATE: begin
        data_rd_value = RST_ZERO;
        if (unit_sel_reg < 8'(UNIT_COUNT)) begin
          data_rd_value = {7'h00, active_reg[unit_sel_reg[2:0]]};
        end
      end
      default:              data_rd_value = RST_ZERO;
    endcase
  end

  // registered read answer
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_reg  <= RST_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= 1'b0;
      if (req_in.rd && hit_index && !quiet && !hard_reset &&
          state_reg == CPSM_CONFIG) begin
        rdata_reg  <= index_reg; // RQ7
        rvalid_reg <= 1'b1;
      end else if (rd_data) begin
        rdata_reg  <= data_rd_value; // RQ8
        rvalid_reg <= 1'b1;
      end
    end
  end

  assign rdata_out            = rdata_reg;
  assign rvalid_out           = rvalid_reg;
  assign config_mode_out      = (state_reg == CPSM_CONFIG);
  assign unit_select_out      = unit_sel_reg;
  assign unit_active_out      = active_reg;
  assign shared_gpio_line_out = gpio_reg;
  assign unit_power_out       = power_ctl_reg;
  assign power_management_out = power_mgmt_reg;

  a_enter_key: assert property ( // RQ4
    @(posedge clock_in) disable iff (!reset_n_in)
    wr_index && state_reg == CPSM_RUN && req_in.wdata == KEY_ENTER
    |=> state_reg == CPSM_CONFIG)
    else $error("entry key not taken");
  a_exit_key: assert property ( // RQ5
    @(posedge clock_in) disable iff (!reset_n_in)
    wr_index && state_reg == CPSM_CONFIG && req_in.wdata == KEY_EXIT
    |=> state_reg == CPSM_RUN)
    else $error("exit key not taken");
  a_run_ignore: assert property ( // RQ16
    @(posedge clock_in) disable iff (!reset_n_in)
    state_reg == CPSM_RUN && !(wr_index && req_in.wdata == KEY_ENTER)
    |=> state_reg == CPSM_RUN)
    else $error("run state left without key");
  a_run_silent: assert property ( // RQ6
    @(posedge clock_in) disable iff (!reset_n_in)
    state_reg == CPSM_RUN |=> !rvalid_reg)
    else $error("read answered in run state");
  a_reset_run: assert property ( // RQ1
    @(posedge clock_in) disable iff (!reset_n_in)
    !bus_reset_n_in |=> state_reg == CPSM_RUN && active_reg == '0)
    else $error("reset did not restore run state");
  a_strap_base: assert property ( // RQ2
    @(posedge clock_in) disable iff (!reset_n_in)
    !power_reset_n_in |=> base_low_reg == $past(strap_low_byte)
      && base_high_reg == RST_ZERO)
    else $error("strap base not loaded");
  a_quiet_block: assert property ( // RQ12
    @(posedge clock_in) disable iff (!reset_n_in)
    $rose(power_reset_n_in) |-> quiet [*8])
    else $error("quiet window too short");
  a_soft_unit: assert property ( // RQ11
    @(posedge clock_in) disable iff (!reset_n_in)
    soft_reset |=> unit_sel_reg == RST_ZERO)
    else $error("soft reset kept unit select");
  a_id_read: assert property ( // RQ14
    @(posedge clock_in) disable iff (!reset_n_in)
    rd_data && index_reg == IDX_PART_IDENTIFIER
    |=> rvalid_reg && rdata_reg == PART_ID_VALUE)
    else $error("id read wrong");
  a_zero_read: assert property ( // RQ13
    @(posedge clock_in) disable iff (!reset_n_in)
    rd_data && index_reg == IDX_RESERVED_ZERO_A
    |=> rdata_reg == RST_ZERO)
    else $error("reserved read not zero");
  a_index_echo: assert property ( // RQ7
    @(posedge clock_in) disable iff (!reset_n_in)
    req_in.rd && hit_index && !quiet && !hard_reset &&
      state_reg == CPSM_CONFIG
    |=> rvalid_reg && rdata_reg == $past(index_reg))
    else $error("index port read wrong");
  a_base_hold: assert property ( // RQ15
    @(posedge clock_in) disable iff (!reset_n_in)
    !bus_fall && power_reset_n_in && !wr_data |=> $stable(base_low_reg))
    else $error("base moved outside reset");

  c_enter: cover property (@(posedge clock_in) disable iff (!reset_n_in)
    state_reg == CPSM_RUN ##1 state_reg == CPSM_CONFIG);
  c_unit_sel: cover property (@(posedge clock_in) disable iff (!reset_n_in)
    wr_data && index_reg == IDX_UNIT_SELECT);
  c_relocate: cover property (@(posedge clock_in) disable iff (!reset_n_in)
    wr_data && index_reg == IDX_PORT_BASE_LOW);
  c_exit: cover property (@(posedge clock_in) disable iff (!reset_n_in)
    state_reg == CPSM_CONFIG ##1 state_reg == CPSM_RUN);

endmodule

// file: cpsm_host_model.sv
// host bus controller model issuing configuration port cycles
`timescale 1ns/1ps
module cpsm_host_model
  import cpsm_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in,
  output cpsm_req_t       req_out
);
  logic [7:0] rd_data;
  logic       rd_got;

  initial req_out = '0;

  // released address and data lines show the inverse of their last value
  task automatic idle();
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~req_out.addr,
                 wdata: ~req_out.wdata};
  endtask

  // keys, index and unit number all go out as single port writes
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_in);
    idle();
    #1;
  endtask

  // read with a bounded wait for the answer
  task automatic rd(input logic [15:0] a);
    rd_got = 1'b0;
    @(posedge clock_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: req_out.wdata};
    @(posedge clock_in);
    idle();
    for (int i = 0; i < 3 && !rd_got; i++) begin
      #1;
      if (rvalid_in === 1'b1) begin
        rd_got = 1'b1;
        rd_data = rdata_in;
      end else begin
        @(posedge clock_in);
      end
    end
  endtask
endmodule

// file: tb_top.sv
// self-checking bench for the configuration port state machine
`timescale 1ns/1ps
module tb_top;
  import cpsm_pkg::*;

  typedef struct packed {
    logic [7:0] idx;
    logic       wen;
    logic [7:0] wval;
    logic [7:0] exp;
  } cpsm_row_t;

  logic                  clock_in;
  logic                  reset_n_in;
  logic                  bus_reset_n_in;
  logic                  power_reset_n_in;
  logic                  strap_in;
  cpsm_req_t             req;
  logic [7:0]            rdata;
  logic                  rvalid;
  logic                  mode;
  logic [7:0]            usel;
  logic [UNIT_COUNT-1:0] uact;
  logic                  gpio;
  logic [7:0]            upow;
  logic [7:0]            pmgmt;
  logic [15:0]           base;
  int                    err_count;
  int                    n_tests;
  cpsm_row_t             rows [8];

  cpsm_config_port DUT (
    .clock_in(clock_in), .reset_n_in(reset_n_in),
    .bus_reset_n_in(bus_reset_n_in), .power_reset_n_in(power_reset_n_in),
    .strap_in(strap_in), .req_in(req), .rdata_out(rdata),
    .rvalid_out(rvalid), .config_mode_out(mode), .unit_select_out(usel),
    .unit_active_out(uact), .shared_gpio_line_out(gpio),
    .unit_power_out(upow), .power_management_out(pmgmt)
  );

  cpsm_host_model host (
    .clock_in(clock_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .req_out(req)
  );

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic report_and_stop();
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    host.rd(a);
    if (host.rd_got !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
    chk(host.rd_data, e);
  endtask

  task automatic set(input logic [7:0] idx, input logic [7:0] val);
    host.wr(base, idx);
    host.wr(base + 16'h0001, val);
  endtask

  initial begin
    err_count = 0;
    n_tests = 0;
    base = BASE_STRAP_LO;
    rows[0] = '{IDX_RESERVED_ZERO_A, 1'b1, 8'hFF, 8'h00};
    rows[1] = '{IDX_PART_IDENTIFIER, 1'b1, 8'h12, PART_ID_VALUE};
    rows[2] = '{IDX_PART_REVISION, 1'b1, 8'h34, PART_REV_VALUE};
    rows[3] = '{IDX_UNIT_POWER, 1'b1, 8'h5A, 8'h5A};
    rows[4] = '{IDX_POWER_MANAGEMENT, 1'b1, 8'h3C, 8'h3C};
    rows[5] = '{IDX_OSCILLATOR, 1'b0, 8'h00, RST_OSCILLATOR};
    rows[6] = '{IDX_TEST_SIX, 1'b1, 8'h81, 8'h81};
    rows[7] = '{IDX_CONFIG_CONTROL, 1'b1, 8'h00, 8'h00};
    reset_n_in = 1'b0;
    bus_reset_n_in = 1'b0;
    power_reset_n_in = 1'b1;
    strap_in = 1'b0;
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    bus_reset_n_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    chk({7'h00, mode}, 8'h00);
    chk(uact, 8'h00);
    repeat (QUIET_CYCLES) @(posedge clock_in);
    host.rd(base + 16'h0001);
    chk({7'h00, host.rd_got}, 8'h00);
    host.wr(base, 8'h12);
    chk({7'h00, mode}, 8'h00);
    host.wr(base, KEY_ENTER);
    chk({7'h00, mode}, 8'h01);
    set(IDX_UNIT_SELECT, 8'h03);
    chk(usel, 8'h03);
    set(IDX_ACTIVATE, 8'h01);
    chk(uact, 8'h08);
    foreach (rows[i]) begin
      if (rows[i].wen) begin
        set(rows[i].idx, rows[i].wval);
      end
      host.wr(base, rows[i].idx);
      rd_chk(base, rows[i].idx);
      rd_chk(base + 16'h0001, rows[i].exp);
    end
    set(IDX_CONFIG_CONTROL, 8'h01);
    chk(usel, 8'h00);
    chk(uact, 8'h00);
    chk(upow, 8'h00);
    chk(pmgmt, 8'h3C);
    set(IDX_PORT_BASE_LOW, 8'h60);
    base = 16'h0060;
    host.wr(base, IDX_PORT_BASE_LOW);
    rd_chk(base + 16'h0001, 8'h60);
    host.wr(base, KEY_EXIT);
    chk({7'h00, mode}, 8'h00);
    host.wr(BASE_STRAP_LO, KEY_ENTER);
    chk({7'h00, mode}, 8'h00);
    host.wr(base, KEY_ENTER);
    @(posedge clock_in);
    strap_in <= 1'b1;
    bus_reset_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1;
    chk({7'h00, mode}, 8'h00);
    @(posedge clock_in);
    bus_reset_n_in <= 1'b1;
    strap_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1;
    chk({7'h00, gpio}, 8'h00);
    @(posedge clock_in);
    strap_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    chk({7'h00, gpio}, 8'h01);
    @(posedge clock_in);
    strap_in <= 1'b0;
    host.wr(BASE_STRAP_HI, KEY_ENTER);
    chk({7'h00, mode}, 8'h01);
    host.wr(BASE_STRAP_HI, IDX_PORT_BASE_LOW);
    rd_chk(BASE_STRAP_HI + 16'h0001, 8'h4E);
    @(posedge clock_in);
    power_reset_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    power_reset_n_in <= 1'b1;
    host.wr(BASE_STRAP_LO, KEY_ENTER);
    chk({7'h00, mode}, 8'h00);
    repeat (QUIET_CYCLES) @(posedge clock_in);
    host.wr(BASE_STRAP_LO, KEY_ENTER);
    chk({7'h00, mode}, 8'h01);
    report_and_stop();
  end
endmodule
